// File: rtl/dacpp_pkg.sv
// constants and types of the dual converter parallel-port host
package dacpp_pkg;
	localparam int DATA_W = 12;
	localparam int CLK_NS = 50;
	localparam int SYNC_STAGES = 2;
	// pin timing figures in ns
	localparam int T_ADDR_SETUP_NS = 10;
	localparam int T_CS_LOW_NS = 10;
	localparam int T_DATA_HOLD_NS = 0;
	localparam int T_CS_HIGH_NS = 7;
	localparam int T_ACCESS_NS = 35;
	localparam int T_RELINQ_NS = 10;
	localparam int T_LOAD_LOW_NS = 50;
	localparam int T_CLR_LOW_NS = 100;

	// least times round up, never below one cycle
	function automatic logic [3:0] nsToCyc(input int ns);
		int c;
		c = (ns + CLK_NS - 1) / CLK_NS;
		if (c < 1) begin
			c = 1;
		end
		return 4'(c);
	endfunction

	localparam logic [3:0] SETUP_CYC = nsToCyc(T_ADDR_SETUP_NS);
	localparam logic [3:0] CS_LOW_CYC = nsToCyc(T_CS_LOW_NS);
	localparam logic [3:0] HOLD_CYC = nsToCyc(T_DATA_HOLD_NS);
	localparam logic [3:0] CS_HIGH_CYC = nsToCyc(T_CS_HIGH_NS);
	localparam logic [3:0] RELINQ_CYC = nsToCyc(T_RELINQ_NS);
	// read strobe also covers the two-flop path of the returning bus
	localparam logic [3:0] READ_LOW_CYC =
		4'(nsToCyc(T_ACCESS_NS) + SYNC_STAGES);
	localparam logic [3:0] LOAD_LOW_CYC = nsToCyc(T_LOAD_LOW_NS);
	localparam logic [3:0] CLR_LOW_CYC = nsToCyc(T_CLR_LOW_NS);
	localparam logic [DATA_W-1:0] DATA_RST = 12'h000;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_SETUP = 3'b001,
		ST_STROBE = 3'b010,
		ST_HOLD = 3'b011,
		ST_GAP = 3'b100
	} dacpp_state_t;
endpackage

// File: rtl/dacpp_sync_if.sv
// bundle between the host engine and its bus synchroniser
`timescale 1ns/100ps
interface dacpp_sync_if #(parameter int W = 12);
	logic [W-1:0] raw;
	logic [W-1:0] synced;
	modport engine (output raw, input synced);
	modport syncer (input raw, output synced);
endinterface

// File: rtl/dacpp_bus_sync.sv
// two-flop synchroniser for the returning parallel data bus
`timescale 1ns/100ps
module dacpp_bus_sync
	import dacpp_pkg::*;
#(
	parameter int W = DATA_W
) (
	// clock and control
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic ce,
	// bus bundle
	dacpp_sync_if.syncer sb
);
	logic [W-1:0] meta_r, meta_nxt;
	logic [W-1:0] stable_r, stable_nxt;

	always_comb begin
		meta_nxt = meta_r;
		stable_nxt = stable_r;
		if (ce) begin
			meta_nxt = sb.raw;
			stable_nxt = meta_r;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			meta_r <= '0;
			stable_r <= '0;
		end else begin
			meta_r <= meta_nxt;
			stable_r <= stable_nxt;
		end
	end

	assign sb.synced = stable_r;
endmodule

// File: rtl/dacpp_host.sv
// host controller driving the dual converter's parallel port pins
`timescale 1ns/100ps
// Functional notes
// - one 12-bit word per access, bit 11 most significant, bit 0 least
// - channel select low addresses channel A, high addresses channel B
// - active-low select with read/write line qualifies every access
// - read/write low writes bus data; high makes device drive register out
// - every write needs a select falling edge then a rising edge
module dacpp_host
	import dacpp_pkg::*;
(
	// clock and control
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic ce,
	// access requests
	input wire logic reqValid,
	output logic reqReady,
	input wire logic reqWrite,
	input wire logic reqChan,
	input wire logic [DATA_W-1:0] reqData,
	output logic rdValid,
	output logic [DATA_W-1:0] rdData,
	// update and clear requests
	input wire logic loadReq,
	input wire logic autoUpdate,
	input wire logic clearReq,
	// converter pins
	output logic selectN,
	output logic readNotWrite,
	output logic channelSelect,
	output logic [DATA_W-1:0] dataOut,
	output logic dataOe,
	input wire logic [DATA_W-1:0] dataIn,
	output logic loadStrobeN,
	output logic clearN
);
	dacpp_sync_if #(.W(DATA_W)) sbus();
	dacpp_state_t state_r, state_nxt;
	logic [3:0] cnt_r, cnt_nxt;
	logic sel_r, sel_nxt;
	logic rnw_r, rnw_nxt;
	logic chan_r, chan_nxt;
	logic [DATA_W-1:0] dout_r, dout_nxt;
	logic oe_r, oe_nxt;
	logic rdv_r, rdv_nxt;
	logic [DATA_W-1:0] rdd_r, rdd_nxt;
	logic [3:0] loadCnt_r, loadCnt_nxt;
	logic [3:0] clrCnt_r, clrCnt_nxt;
	logic auto_r, auto_nxt;

	assign sbus.raw = dataIn;

	dacpp_bus_sync #(.W(DATA_W)) uSync (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.ce(ce),
		.sb(sbus)
	);

	// no access starts while the clear pulse runs
	assign reqReady = ce && (state_r == ST_IDLE) && (clrCnt_r == 4'h0);

	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		sel_nxt = sel_r;
		rnw_nxt = rnw_r;
		chan_nxt = chan_r;
		dout_nxt = dout_r;
		oe_nxt = oe_r;
		rdv_nxt = rdv_r;
		rdd_nxt = rdd_r;
		if (ce) begin
			// the valid pulse only ends on an enabled edge, so a freeze holds it
			rdv_nxt = 1'b0;
			case (state_r)
				ST_IDLE: begin
					if (reqValid && reqReady) begin
						chan_nxt = reqChan;
						rnw_nxt = !reqWrite;
						dout_nxt = reqData;
						oe_nxt = reqWrite;
						cnt_nxt = 4'(SETUP_CYC - 4'h1);
						state_nxt = ST_SETUP;
					end
				end
				ST_SETUP: begin
					if (cnt_r == 4'h0) begin
						sel_nxt = 1'b0;
						cnt_nxt = rnw_r ? 4'(READ_LOW_CYC - 4'h1) :
							4'(CS_LOW_CYC - 4'h1);
						state_nxt = ST_STROBE;
					end else begin
						cnt_nxt = cnt_r - 4'h1;
					end
				end
				ST_STROBE: begin
					if (cnt_r == 4'h0) begin
						if (rnw_r) begin
							rdd_nxt = sbus.synced;
							rdv_nxt = 1'b1;
						end
						// rising edge latches the word in the device
						sel_nxt = 1'b1;
						cnt_nxt = 4'(HOLD_CYC - 4'h1);
						state_nxt = ST_HOLD;
					end else begin
						cnt_nxt = cnt_r - 4'h1;
					end
				end
				ST_HOLD: begin
					if (cnt_r == 4'h0) begin
						oe_nxt = 1'b0;
						// after a read the device needs time to let go
						cnt_nxt = rnw_r ? 4'(RELINQ_CYC - 4'h1) :
							4'(CS_HIGH_CYC - 4'h1);
						rnw_nxt = 1'b1;
						state_nxt = ST_GAP;
					end else begin
						cnt_nxt = cnt_r - 4'h1;
					end
				end
				ST_GAP: begin
					if (cnt_r == 4'h0) begin
						state_nxt = ST_IDLE;
					end else begin
						cnt_nxt = cnt_r - 4'h1;
					end
				end
				default: begin
					state_nxt = ST_IDLE;
					sel_nxt = 1'b1;
					oe_nxt = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			state_r <= ST_IDLE;
			cnt_r <= 4'h0;
			sel_r <= 1'b1;
			rnw_r <= 1'b1;
			chan_r <= 1'b0;
			dout_r <= DATA_RST;
			oe_r <= 1'b0;
			rdv_r <= 1'b0;
			rdd_r <= DATA_RST;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			sel_r <= sel_nxt;
			rnw_r <= rnw_nxt;
			chan_r <= chan_nxt;
			dout_r <= dout_nxt;
			oe_r <= oe_nxt;
			rdv_r <= rdv_nxt;
			rdd_r <= rdd_nxt;
		end
	end

	// load and clear strobes
	always_comb begin
		loadCnt_nxt = loadCnt_r;
		clrCnt_nxt = clrCnt_r;
		auto_nxt = auto_r;
		if (ce) begin
			auto_nxt = autoUpdate;
			if (loadCnt_r != 4'h0) begin
				loadCnt_nxt = loadCnt_r - 4'h1;
			end else if (loadReq && !auto_r) begin
				loadCnt_nxt = LOAD_LOW_CYC;
			end
			if (clrCnt_r != 4'h0) begin
				clrCnt_nxt = clrCnt_r - 4'h1;
			end else if (clearReq) begin
				clrCnt_nxt = CLR_LOW_CYC;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			loadCnt_r <= 4'h0;
			// a clear pulse follows every reset so the converter is zeroed
			clrCnt_r <= CLR_LOW_CYC;
			auto_r <= 1'b0;
		end else begin
			loadCnt_r <= loadCnt_nxt;
			clrCnt_r <= clrCnt_nxt;
			auto_r <= auto_nxt;
		end
	end

	assign selectN = sel_r;
	assign readNotWrite = rnw_r;
	assign channelSelect = chan_r;
	assign dataOut = dout_r;
	assign dataOe = oe_r;
	assign rdValid = rdv_r;
	assign rdData = rdd_r;
	assign loadStrobeN = !(auto_r || (loadCnt_r != 4'h0));
	assign clearN = (clrCnt_r == 4'h0);

	no_read_drive_a: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		dataOe |-> !readNotWrite) else $error("bus driven during read");
	rnw_stable_a: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		!selectN && !$fell(selectN) |-> $stable(readNotWrite))
		else $error("read/write moved while selected");
	chan_stable_a: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		!selectN && !$fell(selectN) |-> $stable(channelSelect))
		else $error("channel moved while selected");
	write_data_edge_a: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		$rose(selectN) && !readNotWrite |-> dataOe && $stable(dataOut))
		else $error("write data unstable at select rise");
	write_pulse_a: assert property (
		@(posedge clk_sys) disable iff (!rst_n || !ce)
		$fell(selectN) && !readNotWrite |-> ##1 selectN)
		else $error("write select pulse not closed");
	// read strobe is low for the access cycle plus the two sync cycles
	read_pulse_a: assert property (
		@(posedge clk_sys) disable iff (!rst_n || !ce)
		$fell(selectN) && readNotWrite |-> !selectN [*3] ##1 selectN)
		else $error("read select pulse length wrong");
	read_capture_a: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		rdValid |-> $rose(selectN) && rdData == $past(sbus.synced))
		else $error("read data not taken at select rise");
	relinq_gap_a: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		$rose(selectN) && readNotWrite |-> !dataOe [*3])
		else $error("bus driven too soon after read");
	auto_load_a: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		ce && autoUpdate |=> !loadStrobeN)
		else $error("auto update not holding load low");
	load_pulse_a: assert property (
		@(posedge clk_sys) disable iff (!rst_n || !ce)
		$fell(loadStrobeN) && !auto_r |-> ##1 loadStrobeN)
		else $error("load strobe width wrong");
	reset_clear_a: assert property (
		@(posedge clk_sys)
		$rose(rst_n) |-> !clearN)
		else $error("no clear after reset");
	clear_block_a: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		!clearN |-> !reqReady)
		else $error("access offered during clear");
	clear_width_a: assert property (
		@(posedge clk_sys) disable iff (!rst_n || !ce)
		$fell(clearN) |-> ##1 !clearN ##1 clearN)
		else $error("clear pulse width wrong");
endmodule

// File: dv/dacpp_dev_model.sv
// behavioural model of the dual converter's parallel port
`timescale 1ns/100ps
module dacpp_dev_model
	import dacpp_pkg::*;
(
	// host pins
	input wire logic selectN,
	input wire logic readNotWrite,
	input wire logic channelSelect,
	input wire logic loadStrobeN,
	input wire logic clearN,
	input wire logic [DATA_W-1:0] busLvl,
	// bus drive and state
	output logic [DATA_W-1:0] busOut,
	output logic busOe,
	output logic [DATA_W-1:0] dacA,
	output logic [DATA_W-1:0] dacB,
	output logic [7:0] wrCnt
);
	logic [DATA_W-1:0] latchA;
	logic [DATA_W-1:0] latchB;
	logic [DATA_W-1:0] lastDrv;
	initial begin
		latchA = '0;
		latchB = '0;
		dacA = '0;
		dacB = '0;
		lastDrv = '0;
		wrCnt = '0;
	end
	assign busOe = !selectN && readNotWrite;
	// no pull on the bus: released lines show the inverse of the last word
	assign busOut = busOe ? (channelSelect ? dacB : dacA) : ~lastDrv;
	always @(negedge busOe) begin
		lastDrv = channelSelect ? dacB : dacA;
	end
	always @(posedge selectN) begin
		if (!readNotWrite && clearN) begin
			wrCnt = wrCnt + 8'h01;
			if (channelSelect) latchB = busLvl;
			else latchA = busLvl;
			if (!loadStrobeN && channelSelect) dacB = busLvl;
			if (!loadStrobeN && !channelSelect) dacA = busLvl;
		end
	end
	always @(negedge loadStrobeN) begin
		dacA = latchA;
		dacB = latchB;
	end
	always @(negedge clearN) begin
		latchA = '0;
		latchB = '0;
		dacA = '0;
		dacB = '0;
	end
endmodule

// File: dv/tb_top.sv
// self-checking bench for the converter port host
`timescale 1ns/100ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin \
	error_cnt++; $display("FAIL %0t got %h want %h", $time, a, b); end end
module tb_top
	import dacpp_pkg::*;
;
	logic clk_sys = 0;
	logic rst_n = 0;
	logic ce = 1;
	logic reqValid = 0, reqWrite = 0, reqChan = 0;
	logic loadReq = 0, autoUpdate = 0, clearReq = 0;
	logic [DATA_W-1:0] reqData = '0;
	logic reqReady, rdValid, selectN, readNotWrite, channelSelect;
	logic dataOe, loadStrobeN, clearN, busOe;
	logic [DATA_W-1:0] rdData, dataOut, dataIn, busOut, dacA, dacB, rd;
	logic [7:0] wrCnt, w0;
	int error_cnt = 0;
	int checks_done = 0;
	always #25 clk_sys = ~clk_sys;
	assign dataIn = dataOe ? dataOut : busOut;
	dacpp_host dacpp_host_i (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce),
		.reqValid(reqValid), .reqReady(reqReady), .reqWrite(reqWrite),
		.reqChan(reqChan), .reqData(reqData), .rdValid(rdValid),
		.rdData(rdData), .loadReq(loadReq), .autoUpdate(autoUpdate),
		.clearReq(clearReq), .selectN(selectN), .readNotWrite(readNotWrite),
		.channelSelect(channelSelect), .dataOut(dataOut), .dataOe(dataOe),
		.dataIn(dataIn), .loadStrobeN(loadStrobeN), .clearN(clearN));
	dacpp_dev_model dacpp_dev_model_i (.selectN(selectN),
		.readNotWrite(readNotWrite), .channelSelect(channelSelect),
		.loadStrobeN(loadStrobeN), .clearN(clearN), .busLvl(dataIn),
		.busOut(busOut), .busOe(busOe), .dacA(dacA), .dacB(dacB),
		.wrCnt(wrCnt));
	// host must never fight the device during a readback
	always @(posedge clk_sys) begin
		if (rst_n && !selectN) `CHK(dataOe && readNotWrite, 1'b0)
	end
	task automatic access(input logic wr, input logic ch,
		input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] r);
		int n;
		r = 'x;
		reqWrite = wr;
		reqChan = ch;
		reqData = d;
		reqValid = 1;
		for (n = 0; n < 50 && reqReady !== 1'b1; n++) begin
			@(posedge clk_sys);
			#1;
		end
		@(posedge clk_sys);
		#1;
		reqValid = 0;
		for (n = 0; n < 12; n++) begin
			if (rdValid === 1'b1) r = rdData;
			@(posedge clk_sys);
			#1;
		end
	endtask
	// one request edge on the clear line or the load line
	task automatic pulse(input logic clr);
		if (clr) clearReq = 1;
		else loadReq = 1;
		@(posedge clk_sys);
		#1;
		clearReq = 0;
		loadReq = 0;
		repeat (4) @(posedge clk_sys);
		#1;
	endtask
	// a frozen host must neither start a load nor offer an access
	task automatic t_freeze;
		ce = 0;
		loadReq = 1;
		@(posedge clk_sys);
		#1;
		`CHK(loadStrobeN, 1'b1)
		`CHK(reqReady, 1'b0)
		loadReq = 0;
		ce = 1;
		@(posedge clk_sys);
		#1;
	endtask
	task automatic t_reset;
		`CHK(clearN, 1'b0)
		access(1'b0, 1'b0, 12'h000, rd);
		`CHK(rd, 12'h000)
		`CHK(dacB, 12'h000)
	endtask
	task automatic t_load;
		w0 = wrCnt;
		access(1'b1, 1'b0, 12'hA5C, rd);
		`CHK(wrCnt, w0 + 8'h01)
		access(1'b0, 1'b0, 12'h000, rd);
		`CHK(rd, 12'h000)
		t_freeze();
		pulse(1'b0);
		access(1'b0, 1'b0, 12'h000, rd);
		`CHK(rd, 12'hA5C)
		access(1'b0, 1'b1, 12'h000, rd);
		`CHK(rd, 12'h000)
	endtask
	task automatic t_auto;
		autoUpdate = 1;
		repeat (3) @(posedge clk_sys);
		#1;
		`CHK(loadStrobeN, 1'b0)
		access(1'b1, 1'b1, 12'h3F1, rd);
		access(1'b1, 1'b1, 12'h800, rd);
		access(1'b0, 1'b1, 12'h000, rd);
		`CHK(rd, 12'h800)
		access(1'b1, 1'b0, 12'h001, rd);
		access(1'b0, 1'b0, 12'h000, rd);
		`CHK(rd, 12'h001)
		autoUpdate = 0;
	endtask
	task automatic t_clear;
		pulse(1'b1);
		access(1'b0, 1'b1, 12'h000, rd);
		`CHK(rd, 12'h000)
		`CHK(dacA, 12'h000)
	endtask
	task automatic close_out;
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge clk_sys);
		#1;
		rst_n = 1;
		t_reset();
		t_load();
		t_auto();
		t_clear();
		close_out();
	end
	initial begin
		#100000;
		error_cnt++;
		close_out();
	end
endmodule
